// [rtl/led_display_pkg.sv]
// Constants, field layout, fonts and state types for the LED display port.
// Assumes one 250 MHz clock and an asynchronous write strobe from a host.
//
// Summary of operation
// RQ1: Write strobe rising edge captures input word.
// RQ2: Mode high loads control, low loads memory.
// RQ3: Lines 0..7 form digit word, top is point.
// RQ4: Line 4 low shuts scan and blanks display.
// RQ5: Line 5 high drives segments raw, undecoded.
// RQ6: Line 6 high hex font, low Code B.
// RQ7: Line 7 high announces sequential data writes.
// RQ8: Lines 0..2 address digit when line 7 low.
// RQ9: Line 3 picks bank A/B in decode modes.
// RQ10: Line 4 high runs scan and display normally.
// RQ11: Scan refreshes each digit at about 390 Hz.
// RQ12: At least 2 us blank between digit drives.
// RQ13: Following eight memory writes fill digits in order.
// RQ14: Single-digit write updates only addressed digit.
package led_display_pkg;

  localparam int          DIGITS        = 8;
  localparam int          IDX_W         = 3;
  localparam int          WORD_W        = 8;
  localparam int          SEG_W         = 7;
  localparam int          BANKS         = 2;

  localparam int          CLK_PERIOD_NS = 4;
  localparam int          CLK_HZ        = 250_000_000;
  localparam int          SCAN_RATE_HZ  = 390;
  localparam int          BLANK_TIME_NS = 2000;
  localparam int          SLOT_CYCLES   = CLK_HZ / (SCAN_RATE_HZ * DIGITS);
  localparam int          BLANK_CYCLES  =
    (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Control word fields
  localparam int          ADDR_LSB      = 0;
  localparam int          BANK_BIT      = 3;
  localparam int          POWER_BIT     = 4;
  localparam int          RAW_BIT       = 5;
  localparam int          FONT_BIT      = 6;
  localparam int          FOLLOW_BIT    = 7;
  localparam int          POINT_BIT     = 7;
  localparam int          NIB_W         = 4;

  // Shut down until the host writes its first control word
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic        BANK_A_IDX    = 1'b0;
  localparam logic        BANK_B_IDX    = 1'b1;
  localparam logic [2:0]  LAST_DIGIT    = 3'h7;

  // Synchroniser vector layout: {write, mode, data}
  localparam int          SYNC_W        = WORD_W + 2;
  localparam int          SYNC_MODE     = WORD_W;
  localparam int          SYNC_WRITE    = WORD_W + 1;

  typedef enum logic [1:0] {FILL_IDLE, FILL_SEQ, FILL_SINGLE} fill_t;

  // Segment order {g,f,e,d,c,b,a}
  function automatic logic [SEG_W-1:0] font(input logic [NIB_W-1:0] nib,
                                            input logic hex);
    logic [SEG_W-1:0] s;
    s = 7'h00;
    unique case (nib)
      4'h0: s = 7'h3F;
      4'h1: s = 7'h06;
      4'h2: s = 7'h5B;
      4'h3: s = 7'h4F;
      4'h4: s = 7'h66;
      4'h5: s = 7'h6D;
      4'h6: s = 7'h7D;
      4'h7: s = 7'h07;
      4'h8: s = 7'h7F;
      4'h9: s = 7'h6F;
      4'hA: s = hex ? 7'h77 : 7'h40;
      4'hB: s = hex ? 7'h7C : 7'h79;
      4'hC: s = hex ? 7'h39 : 7'h76;
      4'hD: s = hex ? 7'h5E : 7'h38;
      4'hE: s = hex ? 7'h79 : 7'h73;
      4'hF: s = hex ? 7'h71 : 7'h00;
    endcase
    return s;
  endfunction

endpackage

// [rtl/scan_if.sv]
// Carrier between the port logic and the digit scanner.
// Assumes both ends share one clock.
`timescale 1ns/1ns
interface scan_if;
  logic       run;
  logic [2:0] digit_idx;
  logic       digit_on;

  modport ctl  (output run, input digit_idx, input digit_on);
  modport scan (input run, output digit_idx, output digit_on);
endinterface

// [rtl/digit_scanner.sv]
// Digit multiplex timer: slot per digit with a blank lead-in.
// Assumes run comes from a register on the same clock.
`timescale 1ns/1ns
module digit_scanner
  import led_display_pkg::*;
#(
  parameter int SLOT   = SLOT_CYCLES,
  parameter int BLANK  = BLANK_CYCLES
) (
  input  wire logic ref_clk_in,
  input  wire logic sys_rst_in,
  scan_if.scan      sc
);

  localparam int CNT_W = $clog2(SLOT);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [IDX_W-1:0] idx;
  } scan_state_t;

  scan_state_t st;
  scan_state_t next_st;

  always_comb begin
    next_st = st;
    if (!sc.run) begin
      // Oscillator stopped: park on the first digit
      next_st.count = '0;
      next_st.idx   = '0;
    end else if (st.count == CNT_W'(SLOT - 1)) begin
      next_st.count = '0;
      next_st.idx   = st.idx + 1'b1; // see RQ11
    end else begin
      next_st.count = st.count + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sc.digit_idx = st.idx;
  // Every slot opens dark, so no two digits ever overlap
  assign sc.digit_on  = sc.run && (st.count >= CNT_W'(BLANK)); // see RQ12

endmodule

// [rtl/led_display_write_port.sv]
// Write port, display memory, control word and drive outputs.
// Assumes host pins are asynchronous and held per the write timing.
`timescale 1ns/1ns
module led_display_write_port
  import led_display_pkg::*;
#(
  parameter int SLOT   = SLOT_CYCLES,
  parameter int BLANK  = BLANK_CYCLES
) (
  input  wire logic              ref_clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              write_strobe_in,
  input  wire logic              mode_sel_in,
  input  wire logic              in_line_0_in,
  input  wire logic              in_line_1_in,
  input  wire logic              in_line_2_in,
  input  wire logic              in_line_3_bank_sel_in,
  input  wire logic              in_line_4_power_sel_in,
  input  wire logic              in_line_5_raw_sel_in,
  input  wire logic              in_line_6_font_sel_in,
  input  wire logic              in_line_7_follow_flag_in,
  output logic       [SEG_W-1:0] segment_drive_out,
  output logic                   point_drive_out,
  output logic      [DIGITS-1:0] digit_drive_out,
  output logic       [WORD_W-1:0] display_control_word_out
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [SYNC_W-1:0]                        sync1;
    logic [SYNC_W-1:0]                        sync2;
    logic [SYNC_W-1:0]                        prev;
    logic [WORD_W-1:0]                        ctrl;
    logic [BANKS-1:0][DIGITS-1:0][WORD_W-1:0] ram;
    logic [IDX_W-1:0]                         ptr;
    fill_t                                    fill;
    logic [SEG_W-1:0]                         seg;
    logic                                     point;
    logic [DIGITS-1:0]                        digit;
  } port_state_t;

  port_state_t st;
  port_state_t next_st;
  scan_if      sc ();

  logic [WORD_W-1:0] pins;
  logic [WORD_W-1:0] word;
  logic [WORD_W-1:0] shown;
  logic              write_edge;
  logic              to_ctrl;
  logic              ram_bank;
  logic              powered;

  logic [SYNC_W-1:0] raw_in;
  logic              raw_mode;
  logic              hex_font;
  logic              bank_a;
  logic              seq_request;
  logic [IDX_W-1:0]  digit_addr;
  logic              mem_write;
  logic              fill_wrap;
  logic              drive_on;
  logic [DIGITS-1:0] digit_we;
  logic [DIGITS-1:0] digit_sel;
  logic [WORD_W-1:0] bank_words [DIGITS];

  assign pins = {in_line_7_follow_flag_in, in_line_6_font_sel_in,
                 in_line_5_raw_sel_in, in_line_4_power_sel_in,
                 in_line_3_bank_sel_in, in_line_2_in, in_line_1_in,
                 in_line_0_in};

  ////////////////////////////////////////////////////////////////////////
  // Synchroniser

  // Strobe, mode and data share one chain so they stay in step
  assign raw_in = {write_strobe_in, mode_sel_in, pins};

  ////////////////////////////////////////////////////////////////////////
  // Capture

  // Word and mode are taken from the sample one clock before the strobe
  // was first seen high, since the host may drop them right at the edge.
  assign write_edge = st.sync2[SYNC_WRITE] && !st.prev[SYNC_WRITE]; // see RQ1
  assign word       = st.prev[WORD_W-1:0];
  assign to_ctrl    = st.prev[SYNC_MODE]; // see RQ2
  assign powered    = st.ctrl[POWER_BIT]; // see RQ4
  // Bank choice only applies while decoding
  assign ram_bank   = raw_mode ? BANK_A_IDX :
                      (bank_a ? BANK_A_IDX : BANK_B_IDX); // see RQ9
  assign sc.run     = powered; // see RQ10

  ////////////////////////////////////////////////////////////////////////
  // Control fields

  // Fields in force come from the stored word; request fields from the
  // word being written, so a new control word acts as soon as it lands.
  assign raw_mode    = st.ctrl[RAW_BIT]; // see RQ5
  assign hex_font    = st.ctrl[FONT_BIT]; // see RQ6
  assign bank_a      = st.ctrl[BANK_BIT]; // see RQ9
  assign seq_request = word[FOLLOW_BIT]; // see RQ7
  assign digit_addr  = word[ADDR_LSB +: IDX_W]; // see RQ8
  assign drive_on    = sc.digit_on && powered; // see RQ4

  ////////////////////////////////////////////////////////////////////////
  // Write enables and display words

  // Memory writes outside an announced fill are dropped here, so a
  // stray strobe can never disturb a digit the host did not address.
  assign mem_write = write_edge && !to_ctrl &&
                     ((st.fill == FILL_SEQ) || (st.fill == FILL_SINGLE));
  // Pointer wraps to digit 0 after the last digit
  assign fill_wrap = (st.ptr == LAST_DIGIT); // see RQ13

  // Only the digit under the fill pointer may change on a write
  for (genvar d = 0; d < DIGITS; d++) begin : g_digit
    assign digit_we[d]   = mem_write && (st.ptr == IDX_W'(d)); // see RQ14
    assign digit_sel[d]  = sc.digit_idx == IDX_W'(d); // see RQ11
    assign bank_words[d] = st.ram[ram_bank][d];
  end

  // Shown word follows the scanner's digit in the bank in force
  assign shown = bank_words[sc.digit_idx];

  ////////////////////////////////////////////////////////////////////////
  // Scanner

  // Scan timing sits in its own module so its counter width follows SLOT
  digit_scanner #(
    .SLOT  (SLOT),
    .BLANK (BLANK)
  ) scanner (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .sc         (sc)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st       = st;
    // Each pin sample moves one stage along the chain every clock
    next_st.sync1 = raw_in;
    next_st.sync2 = st.sync1;
    next_st.prev  = st.sync2;

    if (write_edge) begin
      if (to_ctrl) begin
        next_st.ctrl = word; // see RQ1
        if (seq_request) begin
          next_st.fill = FILL_SEQ; // see RQ7
          next_st.ptr  = '0; // see RQ13
        end else begin
          next_st.fill = FILL_SINGLE;
          next_st.ptr  = digit_addr; // see RQ8
        end
      end else begin
        unique case (st.fill)
          FILL_SEQ: begin
            next_st.ptr = st.ptr + 1'b1; // see RQ13
            if (fill_wrap) begin
              next_st.fill = FILL_IDLE;
            end
          end
          FILL_SINGLE: begin
            next_st.fill = FILL_IDLE;
          end
          FILL_IDLE: begin
            // Unannounced memory writes are dropped
            next_st.fill = FILL_IDLE;
          end
          default: begin
            next_st.fill = FILL_IDLE;
          end
        endcase
      end
    end

    // Writes land in the bank in force, the same one that is shown
    for (int d = 0; d < DIGITS; d++) begin
      if (digit_we[d]) begin
        next_st.ram[ram_bank][d] = word; // see RQ3 RQ13
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Drive

    next_st.seg   = '0;
    next_st.point = 1'b0;
    next_st.digit = '0;
    if (drive_on) begin // see RQ4
      if (raw_mode) begin
        next_st.seg = shown[SEG_W-1:0]; // see RQ5
      end else begin
        next_st.seg = font(shown[NIB_W-1:0], hex_font); // see RQ6
      end
      next_st.point = shown[POINT_BIT]; // see RQ3
      next_st.digit = digit_sel; // see RQ11
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st       <= '0;
      st.ctrl  <= CTRL_RESET;
      st.fill  <= FILL_IDLE;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  // Registered drives keep the pads free of decode glitches
  assign segment_drive_out        = st.seg;
  assign point_drive_out          = st.point;
  assign digit_drive_out          = st.digit;
  assign display_control_word_out = st.ctrl;

endmodule

// [testbench/led_display_write_port_properties.sv]
// Pin-level timing checks for the LED display write port.
// Assumes the host holds word and mode while the strobe is high.
`timescale 1ns/1ns
module led_display_write_port_properties
  import led_display_pkg::*;
#(
  parameter int SLOT  = SLOT_CYCLES,
  parameter int BLANK = BLANK_CYCLES
) (
  input wire logic              ref_clk_in,
  input wire logic              sys_rst_in,
  input wire logic              write_strobe_in,
  input wire logic              mode_sel_in,
  input wire logic              in_line_0_in,
  input wire logic              in_line_1_in,
  input wire logic              in_line_2_in,
  input wire logic              in_line_3_bank_sel_in,
  input wire logic              in_line_4_power_sel_in,
  input wire logic              in_line_5_raw_sel_in,
  input wire logic              in_line_6_font_sel_in,
  input wire logic              in_line_7_follow_flag_in,
  input wire logic [SEG_W-1:0]  segment_drive_out,
  input wire logic              point_drive_out,
  input wire logic [DIGITS-1:0] digit_drive_out,
  input wire logic [WORD_W-1:0] display_control_word_out
);
  logic [7:0] w_in;
  int         on_cnt;
  int         off_cnt;
  assign w_in = {in_line_7_follow_flag_in, in_line_6_font_sel_in,
                 in_line_5_raw_sel_in, in_line_4_power_sel_in,
                 in_line_3_bank_sel_in, in_line_2_in, in_line_1_in,
                 in_line_0_in};
  // Run lengths of lit and dark digit drives
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      on_cnt  <= 0;
      off_cnt <= 0;
    end else begin
      on_cnt  <= (|digit_drive_out) ? on_cnt + 1 : 0;
      off_cnt <= (|digit_drive_out) ? 0 : off_cnt + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence ctrl_write;
    $rose(write_strobe_in) && mode_sel_in;
  endsequence
  sequence mem_write;
    $rose(write_strobe_in) && !mode_sel_in;
  endsequence
  a_drive_onehot: assert property ($onehot0(digit_drive_out))
    else $error("two digit drives lit");
  a_ctrl_prompt: assert property (ctrl_write |-> ##[1:4]
    display_control_word_out == w_in) else $error("control word late");
  a_ctrl_source: assert property ($changed(display_control_word_out)
    |-> $past(mode_sel_in, 2)) else $error("control changed by memory write");
  a_ctrl_data: assert property ($changed(display_control_word_out)
    |-> display_control_word_out == $past(w_in, 2)) else $error("bad word");
  a_mem_keeps: assert property (mem_write |=>
    $stable(display_control_word_out)[*5]) else $error("control disturbed");
  a_dark_off: assert property (!display_control_word_out[POWER_BIT][*4]
    |-> digit_drive_out == '0 && segment_drive_out == '0 && !point_drive_out)
    else $error("display lit in shutdown");
  a_blank_gap: assert property ($rose(|digit_drive_out)
    |-> off_cnt >= BLANK) else $error("blanking gap too short");
  a_slot_len: assert property ($fell(|digit_drive_out)
    && display_control_word_out[POWER_BIT] |-> on_cnt == SLOT - BLANK)
    else $error("digit slot wrong length");
endmodule

bind led_display_write_port led_display_write_port_properties #(
  .SLOT(SLOT), .BLANK(BLANK)) u_props (
  .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
  .write_strobe_in(write_strobe_in), .mode_sel_in(mode_sel_in),
  .in_line_0_in(in_line_0_in), .in_line_1_in(in_line_1_in),
  .in_line_2_in(in_line_2_in), .in_line_3_bank_sel_in(in_line_3_bank_sel_in),
  .in_line_4_power_sel_in(in_line_4_power_sel_in),
  .in_line_5_raw_sel_in(in_line_5_raw_sel_in),
  .in_line_6_font_sel_in(in_line_6_font_sel_in),
  .in_line_7_follow_flag_in(in_line_7_follow_flag_in),
  .segment_drive_out(segment_drive_out), .point_drive_out(point_drive_out),
  .digit_drive_out(digit_drive_out),
  .display_control_word_out(display_control_word_out));

// [testbench/host_model.sv]
// Host model: drives mode, word and write strobe of the port.
// Assumes the port samples on ref_clk_in; drives on its falling edge.
`timescale 1ns/1ns
module host_model (
  input  wire logic       ref_clk_in,
  output logic            strobe_out,
  output logic            mode_out,
  output logic      [7:0] word_out
);
  initial begin
    strobe_out = 1'b0;
    mode_out   = 1'b0;
    word_out   = 8'h00;
  end
  // Setup of 3 clocks covers the two-flop strobe sync
  task automatic put(input logic m, input logic [7:0] w);
    @(negedge ref_clk_in);
    mode_out = m;
    word_out = w;
    repeat (3) @(negedge ref_clk_in);
    strobe_out = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    strobe_out = 1'b0;
    repeat (4) @(negedge ref_clk_in);
    word_out = ~w;
  endtask
endmodule

// [testbench/led_display_write_port_test.sv]
// Self-checking bench for the LED display write port.
// Assumes short scan counts: slot 40 clocks, blank 4 clocks.
`timescale 1ns/1ns
module led_display_write_port_test;
  import led_display_pkg::*;
  logic              ref_clk_in;
  logic              sys_rst_in;
  logic              strobe;
  logic              mode;
  logic [7:0]        word;
  logic [7:0]        ctrl;
  logic [SEG_W-1:0]  seg;
  logic              pt;
  logic [DIGITS-1:0] dig;
  int                err_total;
  int                checked;
  host_model u_host (.ref_clk_in(ref_clk_in), .strobe_out(strobe),
    .mode_out(mode), .word_out(word));
  led_display_write_port #(.SLOT(40), .BLANK(4)) u_dut (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .write_strobe_in(strobe), .mode_sel_in(mode),
    .in_line_0_in(word[0]), .in_line_1_in(word[1]), .in_line_2_in(word[2]),
    .in_line_3_bank_sel_in(word[3]), .in_line_4_power_sel_in(word[4]),
    .in_line_5_raw_sel_in(word[5]), .in_line_6_font_sel_in(word[6]),
    .in_line_7_follow_flag_in(word[7]), .segment_drive_out(seg),
    .point_drive_out(pt), .digit_drive_out(dig),
    .display_control_word_out(ctrl));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Waits for digit d to light; a full scan is 320 clocks
  task automatic show(input int d, input logic [7:0] e);
    int n;
    n = 0;
    while (dig !== (8'h01 << d) && n < 800) begin
      @(negedge ref_clk_in);
      n++;
    end
    chk("digit", 8'h01 << d, dig);
    chk("point and segments", e, {pt, seg});
  endtask
  task automatic t_reset;
    chk("control word", 8'h00, ctrl);
    chk("digit", 8'h00, dig);
  endtask
  // Raw fill of all digits, then a ninth write that must be dropped
  task automatic t_seq_raw;
    u_host.put(1'b1, 8'hB0);
    chk("control word", 8'hB0, ctrl);
    for (int i = 0; i < 8; i++) begin
      u_host.put(1'b0, {i[0], 4'h0, i[2:0]});
    end
    u_host.put(1'b0, 8'hFF);
    for (int i = 0; i < 8; i++) show(i, {i[0], 4'h0, i[2:0]});
  endtask
  task automatic t_single;
    u_host.put(1'b1, 8'h5A);
    u_host.put(1'b0, 8'h8C);
    u_host.put(1'b0, 8'h01);
    show(2, 8'hB9);
    show(3, 8'hCF);
    u_host.put(1'b1, 8'h1A);
    show(2, 8'hF6);
  endtask
  task automatic t_bank;
    u_host.put(1'b1, 8'h52);
    u_host.put(1'b0, 8'h05);
    show(2, 8'h6D);
    u_host.put(1'b1, 8'h5A);
    show(2, 8'hB9);
  endtask
  task automatic t_shutdown;
    u_host.put(1'b1, 8'h00);
    repeat (400) @(negedge ref_clk_in);
    chk("digit", 8'h00, dig);
    u_host.put(1'b1, 8'h50);
    show(0, 8'h3F);
  endtask
  // Reset in mid-run clears control word and memory
  task automatic t_rerst;
    @(negedge ref_clk_in);
    sys_rst_in = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    sys_rst_in = 1'b0;
    repeat (3) @(negedge ref_clk_in);
    chk("control word", 8'h00, ctrl);
    chk("digit", 8'h00, dig);
    u_host.put(1'b1, 8'h5A);
    show(2, 8'h3F);
  endtask
  task automatic finish_test;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    // About 20000 clocks, well over the longest expected run
    #80000;
    err_total++;
    finish_test();
  end
  initial begin
    err_total  = 0;
    checked    = 0;
    sys_rst_in = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    sys_rst_in = 1'b0;
    repeat (3) @(negedge ref_clk_in);
    t_reset();
    t_seq_raw();
    t_single();
    t_bank();
    t_shutdown();
    t_rerst();
    finish_test();
  end
endmodule
